// ==== src/external_trigger_module.sv ====
// Purpose: External trigger module facing the central trigger system
// Assumes: All trigger system signals are on core_clk; event pin is asynchronous
// Notes: Readout writes up to three words per readout trigger
//
// Behaviour
// - Single-cycle request suffices when system idle
// - Hold request through busy until busy drops
// - No data configured means no words written
// - Readout channel returns words, strobes, status, finished
// - Control bit 0 disables module and data
// - Module drives 32-bit read-only status word
// - Extra settings live on separate register port
//
// Design decisions made here: the address-and-strobe port and the address map.

`timescale 1ns/10ps
`default_nettype none

module external_trigger_module #(
    parameter int TS_W = etm_pkg::STS_TS_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Asynchronous event source
    input wire logic event_pin,
    // Trigger handshake
    output logic trg_req_out,
    input wire logic busy_in,
    // Readout channel
    input wire logic rdo_trg_in,
    output logic [31:0] rdo_data_out,
    output logic rdo_write_out,
    output logic [31:0] readout_status_bits_out,
    output logic rdo_finished_out,
    // Words managed by the trigger system
    input wire logic [31:0] control_word_in,
    output logic [31:0] status_word_out,
    // Local register port
    input wire logic [etm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    generate
        if (TS_W != etm_pkg::STS_TS_W) begin : g_bad_ts
            $error("TS_W must match the status timestamp field");
        end
    endgenerate

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    event_if #(.TS_W(TS_W)) ev ();

    pin_event_detect #(.TS_W(TS_W)) u_detect (
        .core_clk(core_clk),
        .rst(rst),
        .event_pin(event_pin),
        .ev(ev)
    );

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    etm_pkg::trg_state_e trg_state_r, trg_state_nxt; // Trigger handshake state
    etm_pkg::ro_state_e ro_state_r, ro_state_nxt;    // Readout sequence state
    logic [etm_pkg::CFG_W-1:0] cfg_r;                // Local configuration
    logic [etm_pkg::CNT_W-1:0] evt_cnt_r;            // Accepted events
    logic [etm_pkg::CNT_W-1:0] lost_cnt_r;           // Lost events
    logic [TS_W-1:0] last_ts_r;                      // Timestamp of last accept
    logic err_r, err_nxt;                            // Sticky lost flag
    logic lost_since_r;                              // Lost since last readout
    logic rdo_trg_d_r;                               // Readout trigger history
    logic [1:0] idx_r;                               // Readout word index
    logic [31:0] snap_cnt_r, snap_ts_r, snap_lost_r; // Frozen readout data
    logic [31:0] data_r;
    logic write_r;
    logic fin_r;
    logic [31:0] rdata_r;

    // Decoded controls
    wire disabled = control_word_in[etm_pkg::CTL_DISABLE_BIT];
    wire clr_err = control_word_in[etm_pkg::CTL_CLR_ERR_BIT];
    wire cfg_hold = cfg_r[etm_pkg::CFG_HOLD_BIT];
    wire [1:0] cfg_words = cfg_r[etm_pkg::CFG_WORDS_LSB +: etm_pkg::CFG_WORDS_W];
    wire ev_go = ev.event_pulse & ~disabled;
    wire ev_accept = ev_go & (trg_state_r == etm_pkg::TRG_IDLE);
    wire drop_busy = (trg_state_r == etm_pkg::TRG_REQ) & busy_in & ~cfg_hold;
    wire lost_evt = (ev_go & (trg_state_r != etm_pkg::TRG_IDLE)) | drop_busy;
    wire ro_start = rdo_trg_in & ~rdo_trg_d_r;
    wire ro_empty = disabled | (cfg_words == 2'h0);
    wire wr_cfg = reg_wr & (reg_addr == etm_pkg::REG_CONFIG);

    // Select one readout word by index
    function automatic logic [31:0] word_sel(input logic [1:0] idx,
                                             input logic [31:0] w0,
                                             input logic [31:0] w1,
                                             input logic [31:0] w2);
        case (idx)
            2'h0: word_sel = w0;
            2'h1: word_sel = w1;
            default: word_sel = w2;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Trigger handshake
    // ------------------------------------------------------------
    // Request is high in any state but idle, so reset forces it low
    assign trg_req_out = (trg_state_r != etm_pkg::TRG_IDLE);

    always_comb begin
        trg_state_nxt = trg_state_r;
        case (trg_state_r)
            etm_pkg::TRG_IDLE: begin
                if (ev_go) begin
                    trg_state_nxt = etm_pkg::TRG_REQ;
                end
            end
            etm_pkg::TRG_REQ: begin
                // Busy seen: either keep asking or give up and flag it
                if (busy_in && cfg_hold) begin
                    trg_state_nxt = etm_pkg::TRG_HOLD;
                end else begin
                    trg_state_nxt = etm_pkg::TRG_IDLE;
                end
            end
            etm_pkg::TRG_HOLD: begin
                // Drop only after one cycle with busy low, so it is taken
                if (!busy_in) begin
                    trg_state_nxt = etm_pkg::TRG_IDLE;
                end
            end
            default: begin
                trg_state_nxt = etm_pkg::TRG_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trg_state_r <= etm_pkg::TRG_IDLE;
        end else begin
            trg_state_r <= trg_state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Event bookkeeping and status word
    // ------------------------------------------------------------
    // A new loss wins over a clear in the same cycle
    assign err_nxt = lost_evt | (err_r & ~clr_err);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            evt_cnt_r <= '0;
            lost_cnt_r <= '0;
            last_ts_r <= '0;
            err_r <= 1'b0;
        end else begin
            err_r <= err_nxt;
            if (ev_accept) begin
                evt_cnt_r <= evt_cnt_r + 1'b1;
                last_ts_r <= ev.event_ts;
            end
            if (lost_evt) begin
                lost_cnt_r <= lost_cnt_r + 1'b1;
            end
        end
    end

    // Status word: last timestamp low, sticky error on top
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_word_out <= '0;
        end else begin
            status_word_out <= '0;
            status_word_out[TS_W-1:0] <= ev_accept ? ev.event_ts : last_ts_r;
            status_word_out[etm_pkg::STS_ERR_BIT] <= err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Readout sequence
    // ------------------------------------------------------------
    always_comb begin
        ro_state_nxt = ro_state_r;
        case (ro_state_r)
            etm_pkg::RO_IDLE: begin
                if (ro_start) begin
                    ro_state_nxt = ro_empty ? etm_pkg::RO_FINISH : etm_pkg::RO_WRITE;
                end
            end
            etm_pkg::RO_WRITE: begin
                if (idx_r == cfg_words - 2'h1) begin
                    ro_state_nxt = etm_pkg::RO_FINISH;
                end
            end
            etm_pkg::RO_FINISH: begin
                ro_state_nxt = etm_pkg::RO_WAIT;
            end
            etm_pkg::RO_WAIT: begin
                // A new readout needs the trigger to fall first
                if (!rdo_trg_in) begin
                    ro_state_nxt = etm_pkg::RO_IDLE;
                end
            end
            default: begin
                ro_state_nxt = etm_pkg::RO_IDLE;
            end
        endcase
    end

    // State, index and frozen data; freezing keeps words consistent
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ro_state_r <= etm_pkg::RO_IDLE;
            rdo_trg_d_r <= 1'b0;
            idx_r <= 2'h0;
            snap_cnt_r <= '0;
            snap_ts_r <= '0;
            snap_lost_r <= '0;
        end else begin
            ro_state_r <= ro_state_nxt;
            rdo_trg_d_r <= rdo_trg_in;
            if (ro_start) begin
                idx_r <= 2'h0;
                snap_cnt_r <= {{(32 - etm_pkg::CNT_W){1'b0}}, evt_cnt_r};
                snap_ts_r <= {{(32 - TS_W){1'b0}}, last_ts_r};
                snap_lost_r <= {{(32 - etm_pkg::CNT_W){1'b0}}, lost_cnt_r};
            end else if (ro_state_r == etm_pkg::RO_WRITE) begin
                idx_r <= idx_r + 2'h1;
            end
        end
    end

    // Registered channel outputs: one strobe per word, then finished
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_r <= '0;
            write_r <= 1'b0;
            fin_r <= 1'b0;
            lost_since_r <= 1'b0;
            readout_status_bits_out <= '0;
        end else begin
            write_r <= (ro_state_r == etm_pkg::RO_WRITE);
            data_r <= word_sel(idx_r, snap_cnt_r, snap_ts_r, snap_lost_r);
            fin_r <= (ro_state_r == etm_pkg::RO_FINISH);
            if (ro_state_r == etm_pkg::RO_FINISH) begin
                readout_status_bits_out <= '0;
                readout_status_bits_out[etm_pkg::RDO_STS_LOST_BIT] <= lost_since_r | lost_evt;
                lost_since_r <= 1'b0;
            end else if (lost_evt) begin
                lost_since_r <= 1'b1;
            end
        end
    end

    assign rdo_data_out = data_r;
    assign rdo_write_out = write_r;
    assign rdo_finished_out = fin_r;

    // ------------------------------------------------------------
    // Local register port
    // ------------------------------------------------------------
    // Settings beyond the managed words live here
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_r <= etm_pkg::CFG_RESET;
            rdata_r <= '0;
        end else begin
            if (wr_cfg) begin
                cfg_r <= reg_wdata[etm_pkg::CFG_W-1:0];
            end
            if (reg_rd) begin
                case (reg_addr)
                    etm_pkg::REG_CONFIG: rdata_r <= {{(32 - etm_pkg::CFG_W){1'b0}}, cfg_r};
                    etm_pkg::REG_EVENTS: rdata_r <= {{(32 - etm_pkg::CNT_W){1'b0}}, evt_cnt_r};
                    etm_pkg::REG_LOST: rdata_r <= {{(32 - etm_pkg::CNT_W){1'b0}}, lost_cnt_r};
                    default: rdata_r <= '0;
                endcase
            end else begin
                rdata_r <= '0;
            end
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_start_data;
        ro_start && (ro_state_r == etm_pkg::RO_IDLE) && !ro_empty;
    endsequence

    sequence s_two_writes_fin;
        ##2 rdo_write_out ##1 rdo_write_out ##1 (rdo_finished_out && !rdo_write_out);
    endsequence

    sequence s_cfg_write_read;
        wr_cfg ##1 (reg_rd && reg_addr == etm_pkg::REG_CONFIG);
    endsequence

    a_req_from_idle: assert property (
        (trg_state_r == etm_pkg::TRG_IDLE) && ev_go |=> trg_req_out)
        else $error("request not raised after event");
    a_req_drop_free: assert property (
        trg_req_out && !busy_in |=> !trg_req_out)
        else $error("request not dropped after free cycle");
    a_req_hold_busy: assert property (
        trg_req_out && busy_in && cfg_hold |=> trg_req_out)
        else $error("request dropped while busy");
    // The default disable would switch this check off whenever reset is high
    a_reset_idle_out: assert property (@(posedge core_clk) disable iff (1'b0)
        rst |=> !trg_req_out && !rdo_write_out && !rdo_finished_out)
        else $error("outputs active after reset");
    a_no_data_off: assert property (
        ro_start && (ro_state_r == etm_pkg::RO_IDLE) && ro_empty
        |=> (!rdo_write_out)[*3])
        else $error("data written while no data expected");
    a_words_two_fin: assert property (
        s_start_data and (cfg_words == 2'h2) |-> s_two_writes_fin)
        else $error("two-word readout sequence wrong");
    a_fin_after_write: assert property (
        $fell(rdo_write_out) |-> rdo_finished_out)
        else $error("finished not right after last word");
    a_fin_once: assert property (
        rdo_finished_out |=> (!rdo_finished_out)[*2])
        else $error("finished repeated");
    a_status_err_set: assert property (
        lost_evt |=> status_word_out[etm_pkg::STS_ERR_BIT])
        else $error("lost event not flagged in status");
    a_status_ts_cap: assert property (
        ev_accept |=> status_word_out[TS_W-1:0] == $past(ev.event_ts))
        else $error("status timestamp not captured");
    a_cfg_readback: assert property (
        s_cfg_write_read |=> reg_rdata[etm_pkg::CFG_W-1:0] == $past(reg_wdata[2:0], 2))
        else $error("config readback mismatch");

endmodule

`default_nettype wire

// ==== src/etm_pkg.sv ====
// Purpose: Shared constants and state types of the external trigger module
// Assumes: One 50 MHz core clock, synchronous active-high reset
// Notes: Local register offsets are word indices on the plain register port

package etm_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20; // Core clock period at 50 MHz

    // ------------------------------------------------------------
    // Local register port map
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 4;
    localparam logic [3:0] REG_CONFIG = 4'h0; // Hold enable and word count
    localparam logic [3:0] REG_EVENTS = 4'h1; // Accepted event counter (read only)
    localparam logic [3:0] REG_LOST = 4'h2;   // Lost event counter (read only)

    // Configuration register fields
    localparam int CFG_HOLD_BIT = 0;          // Keep request up through busy
    localparam int CFG_WORDS_LSB = 1;         // Readout words per event, 0..3
    localparam int CFG_WORDS_W = 2;
    localparam int CFG_W = 3;
    localparam logic [2:0] CFG_RESET = 3'h3;  // Hold on, one readout word

    // Control word from the trigger system
    localparam int CTL_DISABLE_BIT = 0;       // Module disabled
    localparam int CTL_CLR_ERR_BIT = 1;       // Clears the sticky error flag

    // Status word to the trigger system
    localparam int STS_TS_W = 24;             // Timestamp of last accepted event
    localparam int STS_ERR_BIT = 31;          // Sticky lost-event flag

    // Readout status bits
    localparam int RDO_STS_LOST_BIT = 0;      // Events were lost since last readout

    // Counter width
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TRG_IDLE = 2'b00,
        TRG_REQ = 2'b01,
        TRG_HOLD = 2'b10
    } trg_state_e;

    typedef enum logic [1:0] {
        RO_IDLE = 2'b00,
        RO_WRITE = 2'b01,
        RO_FINISH = 2'b10,
        RO_WAIT = 2'b11
    } ro_state_e;

endpackage

// ==== src/event_if.sv ====
// Purpose: Carries detected pin events and their timestamps
// Assumes: Driven and read in the core clock domain
// Notes: Pulse is one cycle long; timestamp is valid with it

`timescale 1ns/10ps
`default_nettype none

interface event_if #(
    parameter int TS_W = 24
);
    logic event_pulse;          // One-cycle event strobe
    logic [TS_W-1:0] event_ts;  // Timestamp captured with the edge

    modport src (output event_pulse, output event_ts);
    modport snk (input event_pulse, input event_ts);
endinterface

`default_nettype wire

// ==== src/pin_event_detect.sv ====
// Purpose: Synchronise the event pin and stamp each rising edge
// Assumes: Pin is asynchronous to core_clk and stays high at least two cycles
// Notes: Adds three cycles of latency from pin to pulse

`timescale 1ns/10ps
`default_nettype none

module pin_event_detect #(
    parameter int TS_W = 24
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Asynchronous event pin
    input wire logic event_pin,
    // Detected events
    event_if.src ev
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    generate
        if (TS_W < 1 || TS_W > 31) begin : g_bad_ts
            $error("TS_W must lie between 1 and 31");
        end
    endgenerate

    logic sync1_r;              // First stage, read by second stage only
    logic sync2_r;              // Second stage, safe to use
    logic prev_r;               // Delayed copy for edge detection
    logic [TS_W-1:0] ts_r;      // Free-running timestamp
    logic pulse_r;              // Registered event strobe
    logic [TS_W-1:0] stamp_r;   // Registered event timestamp
    logic rise;                 // Rising edge seen

    assign rise = sync2_r & ~prev_r;

    // Two-flop synchroniser and edge history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= event_pin;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Timestamp counter and capture on each edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ts_r <= '0;
            pulse_r <= 1'b0;
            stamp_r <= '0;
        end else begin
            ts_r <= ts_r + 1'b1;
            pulse_r <= rise;
            if (rise) begin
                stamp_r <= ts_r;
            end
        end
    end

    assign ev.event_pulse = pulse_r;
    assign ev.event_ts = stamp_r;

endmodule

`default_nettype wire

// ==== sim/trig_sys_model.sv ====
// Purpose: Trigger system stand-in facing the external trigger module
// Assumes: One core clock, synchronous active-high reset
// Notes: Dead time, control word and readout start come from the bench
`timescale 1ns/10ps
`default_nettype none
module trig_sys_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench controls
    input wire logic [7:0] dead_cyc,
    input wire logic [31:0] ctl,
    input wire logic rdo_go,
    // Module side
    input wire logic trg_req_out,
    output logic busy_in,
    output logic [31:0] control_word_in,
    output logic rdo_trg_in,
    input wire logic [31:0] rdo_data_out,
    input wire logic rdo_write_out,
    input wire logic [31:0] readout_status_bits_out,
    input wire logic rdo_finished_out,
    // Observations for the bench
    output logic [15:0] n_trg_r,
    output logic [15:0] n_fin_r,
    output logic [3:0] n_wr_r,
    output logic [31:0] first_r,
    output logic [31:0] sts_r
);
    // ----------------
    // Trigger side
    // ----------------
    logic [7:0] dead_r; // Dead time left
    // Identifier slot of the one add-on module in this build
    localparam logic [7:0] MODULE_ID = 8'h60;
    // Left at this value the module counts as absent
    localparam logic [7:0] ID_DEFAULT = 8'h00;
    // Requests are taken only from a present module
    wire logic present = (MODULE_ID != ID_DEFAULT);

    // Takes a request only while idle, so a held one waits out the dead time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dead_r <= 8'h00;
            busy_in <= 1'b0;
            n_trg_r <= 16'h0000;
        end else if (dead_r != 8'h00) begin
            dead_r <= dead_r - 8'h01;
            busy_in <= (dead_r != 8'h01);
        end else if (present && trg_req_out === 1'b1) begin
            dead_r <= dead_cyc;
            busy_in <= 1'b1;
            n_trg_r <= n_trg_r + 16'h0001;
        end
    end

    // Control word leaves a register, never a gate
    always_ff @(posedge core_clk) begin
        control_word_in <= rst ? 32'h00000000 : ctl;
    end

    // ----------------
    // Readout side
    // ----------------
    // Trigger held until finished; words and status captured
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdo_trg_in <= 1'b0;
            n_fin_r <= 16'h0000;
            n_wr_r <= 4'h0;
            first_r <= 32'h00000000;
            sts_r <= 32'h00000000;
        end else if (rdo_go) begin
            rdo_trg_in <= 1'b1;
            n_wr_r <= 4'h0;
        end else begin
            if (rdo_write_out === 1'b1) begin
                n_wr_r <= n_wr_r + 4'h1;
                first_r <= (n_wr_r == 4'h0) ? rdo_data_out : first_r;
            end
            if (rdo_finished_out === 1'b1) begin
                rdo_trg_in <= 1'b0;
                n_fin_r <= n_fin_r + 16'h0001;
                sts_r <= readout_status_bits_out;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/tb_external_trigger_module.sv ====
// Purpose: Self-checking bench for the external trigger module
// Assumes: 50 MHz core clock, synchronous active-high reset
// Notes: Expected event counts are tracked by hand across tests
`timescale 1ns/10ps
`default_nettype none
module tb_external_trigger_module;
    // ----------------
    // Stimulus and wiring
    // ----------------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic event_pin = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] dead_cyc = 8'h3C; // Long, so a second event lands inside it
    logic [31:0] ctl = 32'h00000000;
    logic rdo_go = 1'b0;
    wire logic trg_req_out, busy_in, rdo_trg_in, rdo_write_out, rdo_finished_out;
    wire logic [31:0] control_word_in, rdo_data_out, readout_status_bits_out;
    wire logic [31:0] status_word_out, reg_rdata, first_word, rdo_sts;
    wire logic [15:0] n_trg, n_fin;
    wire logic [3:0] n_wr;
    int n_fail = 0;
    int tests_run = 0;
    int w; // Request width in cycles
    logic [31:0] d; // Read data

    always #(etm_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    external_trigger_module dut (.core_clk(core_clk), .rst(rst), .event_pin(event_pin),
        .trg_req_out(trg_req_out), .busy_in(busy_in), .rdo_trg_in(rdo_trg_in),
        .rdo_data_out(rdo_data_out), .rdo_write_out(rdo_write_out),
        .readout_status_bits_out(readout_status_bits_out),
        .rdo_finished_out(rdo_finished_out), .control_word_in(control_word_in),
        .status_word_out(status_word_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    trig_sys_model far (.core_clk(core_clk), .rst(rst), .dead_cyc(dead_cyc), .ctl(ctl),
        .rdo_go(rdo_go), .trg_req_out(trg_req_out), .busy_in(busy_in),
        .control_word_in(control_word_in), .rdo_trg_in(rdo_trg_in),
        .rdo_data_out(rdo_data_out), .rdo_write_out(rdo_write_out),
        .readout_status_bits_out(readout_status_bits_out),
        .rdo_finished_out(rdo_finished_out), .n_trg_r(n_trg), .n_fin_r(n_fin),
        .n_wr_r(n_wr), .first_r(first_word), .sts_r(rdo_sts));

    // ----------------
    // Tasks
    // ----------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Write then read back with no gap between the two strobes
    task automatic reg_write_read(input logic [3:0] a, input logic [31:0] v,
                                  output logic [31:0] r);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        r = reg_rdata;
    endtask

    // Pin high four cycles, then low; counts request cycles meanwhile
    task automatic fire(output int width);
        width = 0;
        @(posedge core_clk);
        event_pin <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(posedge core_clk);
            if (k == 3) event_pin <= 1'b0;
            #1;
            if (trg_req_out === 1'b1) width++;
        end
    endtask

    // One readout; finished must come exactly once
    task automatic readout();
        logic [15:0] f0;
        f0 = n_fin;
        @(posedge core_clk);
        rdo_go <= 1'b1;
        @(posedge core_clk);
        rdo_go <= 1'b0;
        for (int k = 0; k < 20 && n_fin == f0; k++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        check({16'h0000, n_fin - f0}, 32'h00000001);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the roughly 460 cycles the tests need
    initial begin
        #(etm_pkg::CLK_PERIOD_NS * 5000);
        n_fail++;
        print_verdict();
    end

    // ----------------
    // Test sequence
    // ----------------
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        reg_read(etm_pkg::REG_CONFIG, d);
        check(d, 32'h00000003);
        check({31'h0, trg_req_out}, 32'h00000000);
        check(status_word_out, 32'h00000000);
        reg_read(4'hF, d);
        check(d, 32'h00000000);
        // Idle system: one-cycle request is enough
        fire(w);
        check(32'(w), 32'h00000001);
        check({16'h0000, n_trg}, 32'h00000001);
        // Second event inside the dead time is held until busy drops
        fire(w);
        fire(w);
        check(32'(w > 1), 32'h00000001);
        // The held request is only taken once the dead time runs out
        repeat (8) @(posedge core_clk);
        check({16'h0000, n_trg}, 32'h00000003);
        repeat (70) @(posedge core_clk);
        // Hold off: the event inside the dead time is lost
        reg_write(etm_pkg::REG_CONFIG, 32'h00000002);
        fire(w);
        fire(w);
        check(32'(w), 32'h00000001);
        check({16'h0000, n_trg}, 32'h00000004);
        reg_read(etm_pkg::REG_LOST, d);
        check(d, 32'h00000001);
        check({31'h0, status_word_out[31]}, 32'h00000001);
        ctl <= 32'h00000002;
        repeat (2) @(posedge core_clk);
        ctl <= 32'h00000000;
        repeat (2) @(posedge core_clk);
        #1;
        check({31'h0, status_word_out[31]}, 32'h00000000);
        repeat (60) @(posedge core_clk);
        // Every word count from none to three
        for (int k = 0; k < 4; k++) begin
            reg_write_read(etm_pkg::REG_CONFIG, 32'(k * 2 + 1), d);
            check(d, 32'(k * 2 + 1));
            readout();
            check({28'h0, n_wr}, 32'(k));
            if (k == 0) check(rdo_sts, 32'h00000001);
            if (k == 1) check(rdo_sts, 32'h00000000);
            // The event dropped in the busy window was accepted first, then lost
            if (k > 0) check(first_word, 32'h00000005);
        end
        // Disabled: no request, no words, finished still given
        ctl <= 32'h00000001;
        repeat (2) @(posedge core_clk);
        fire(w);
        check(32'(w), 32'h00000000);
        readout();
        check({28'h0, n_wr}, 32'h00000000);
        reg_read(etm_pkg::REG_EVENTS, d);
        check(d, 32'h00000005);
        print_verdict();
    end
endmodule
`default_nettype wire
